// >>> hw/mcgclk_top.v
`include "mcgclk_defs.vh"
`default_nettype none
module mcgclk_top (
  input  wire        ref_clk_in,
  input  wire        resetn_in,
  input  wire [15:0] sfr_addr_in,
  input  wire [7:0]  sfr_wdata_in,
  input  wire        sfr_wr_in,
  input  wire        sfr_rd_in,
  input  wire [7:0]  port3_pin_in,
  output reg  [7:0]  sfr_rdata_out,
  output reg  [7:0]  port3_out,
  output reg  [7:0]  port3_oe_out,
  output reg         coded_serial_out
);
  // ----------------------------------------
  // Transmit states
  // ----------------------------------------
  localparam [1:0] TX_IDLE   = 2'b00;
  localparam [1:0] TX_FIRST  = 2'b01;
  localparam [1:0] TX_SECOND = 2'b10;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Direction bits are 1 for input, so reset leaves every pin released.
  reg  [7:0] port3_direction_q;
  reg  [7:0] port3_direction_d;
  reg  [7:0] port3_latch_q;
  reg  [7:0] port3_latch_d;
  reg  [2:0] codegen_clock_select_q;
  reg  [2:0] codegen_clock_select_d;
  reg        codegen_power_enable_q;
  reg        codegen_power_enable_d;
  reg  [7:0] shift_q;
  reg  [7:0] shift_d;
  reg  [2:0] bit_cnt_q;
  reg  [2:0] bit_cnt_d;
  reg  [1:0] tx_state_q;
  reg  [1:0] tx_state_d;
  reg        coded_d;
  reg  [7:0] port3_d;
  reg  [7:0] port3_oe_d;
  reg  [7:0] rdata_d;
  wire       tx_busy;
  wire       base_tick;
  wire       wr_dir;
  wire       wr_sel;
  wire       wr_ctl;
  wire       wr_dat;
  wire       wr_lat;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign wr_dir  = sfr_wr_in && (sfr_addr_in == `MCGCLK_ADDR_PORT3_DIR);
  assign wr_sel  = sfr_wr_in && (sfr_addr_in == `MCGCLK_ADDR_CLK_SEL);
  assign wr_ctl  = sfr_wr_in && (sfr_addr_in == `MCGCLK_ADDR_MAIN_CTL);
  assign wr_dat  = sfr_wr_in && (sfr_addr_in == `MCGCLK_ADDR_TX_DATA);
  assign wr_lat  = sfr_wr_in && (sfr_addr_in == `MCGCLK_ADDR_PORT3_LATCH);
  assign tx_busy = (tx_state_q != TX_IDLE);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @* begin
    port3_direction_d      = port3_direction_q;
    port3_latch_d          = port3_latch_q;
    codegen_clock_select_d = codegen_clock_select_q;
    codegen_power_enable_d = codegen_power_enable_q;
    // Writes to unmapped addresses fall through and change nothing.
    if (wr_dir) begin
      port3_direction_d = sfr_wdata_in;
    end
    if (wr_lat) begin
      port3_latch_d = sfr_wdata_in;
    end
    // The divider is held while power is off, so a select change made
    // per the software sequence never produces a runt base tick.
    if (wr_sel) begin
      codegen_clock_select_d = sfr_wdata_in[2:0];
    end
    if (wr_ctl) begin
      codegen_power_enable_d = sfr_wdata_in[`MCGCLK_POWER_BIT];
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port3_direction_q      <= `MCGCLK_RST_PORT3_DIR;
      port3_latch_q          <= `MCGCLK_RST_ZERO;
      codegen_clock_select_q <= `MCGCLK_RST_CLK_SEL;
      codegen_power_enable_q <= 1'b0;
    end else begin
      port3_direction_q      <= port3_direction_d;
      port3_latch_q          <= port3_latch_d;
      codegen_clock_select_q <= codegen_clock_select_d;
      codegen_power_enable_q <= codegen_power_enable_d;
    end
  end

  // ----------------------------------------
  // Base clock divider
  // ----------------------------------------
  mcgclk_div #(
    .CW(5)
  ) u_div (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .run_in     (codegen_power_enable_q),
    .sel_in     (codegen_clock_select_q),
    .tick_out   (base_tick)
  );

  // ----------------------------------------
  // Manchester shifter
  // ----------------------------------------
  always @* begin
    tx_state_d = tx_state_q;
    shift_d    = shift_q;
    bit_cnt_d  = bit_cnt_q;
    coded_d    = coded_serial_out;
    if (!codegen_power_enable_q) begin
      // Dropping power aborts a frame and parks the line low.
      tx_state_d = TX_IDLE;
      coded_d    = 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (wr_dat) begin
            shift_d    = sfr_wdata_in;
            bit_cnt_d  = `MCGCLK_RST_BIT_CNT;
            tx_state_d = TX_FIRST;
          end else if (base_tick) begin
            // Idle line rests low after the last bit period ends.
            coded_d = 1'b0;
          end
        end
        TX_FIRST: begin
          // First half carries the inverse, so a 0 falls at mid-period.
          if (base_tick) begin
            coded_d    = ~shift_q[7];
            tx_state_d = TX_SECOND;
          end
        end
        TX_SECOND: begin
          // Second half carries the bit itself, then the next bit moves up.
          if (base_tick) begin
            coded_d   = shift_q[7];
            shift_d   = {shift_q[6:0], 1'b0};
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == `MCGCLK_LAST_BIT) begin
              tx_state_d = TX_IDLE;
            end else begin
              tx_state_d = TX_FIRST;
            end
          end
        end
        default: begin
          // Unused state codes fall back to idle rather than hang the line.
          tx_state_d = TX_IDLE;
          coded_d    = 1'b0;
        end
      endcase
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_q       <= TX_IDLE;
      shift_q          <= `MCGCLK_RST_ZERO;
      bit_cnt_q        <= `MCGCLK_RST_BIT_CNT;
      coded_serial_out <= 1'b0;
    end else begin
      tx_state_q       <= tx_state_d;
      shift_q          <= shift_d;
      bit_cnt_q        <= bit_cnt_d;
      coded_serial_out <= coded_d;
    end
  end

  // ----------------------------------------
  // Pins and read path
  // ----------------------------------------
  always @* begin
    port3_d    = port3_latch_q;
    port3_oe_d = ~port3_direction_q;
    // The coded stream is ORed with the latch, hence the latch must be 0.
    port3_d[`MCGCLK_CODED_PIN] = port3_latch_q[`MCGCLK_CODED_PIN] | coded_serial_out;
  end

  // Outputs are registered so the pins never see decode glitches.
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port3_out     <= `MCGCLK_RST_ZERO;
      port3_oe_out  <= `MCGCLK_RST_ZERO;
      sfr_rdata_out <= `MCGCLK_RST_ZERO;
    end else begin
      port3_out     <= port3_d;
      port3_oe_out  <= port3_oe_d;
      if (sfr_rd_in) begin
        sfr_rdata_out <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  // Reads of the latch address return the pin levels, not the latch.
  // The power bit is read back together with the busy flag in bit 0.
  always @* begin
    rdata_d = 8'h00;
    case (sfr_addr_in)
      `MCGCLK_ADDR_PORT3_DIR:   rdata_d = port3_direction_q;
      `MCGCLK_ADDR_CLK_SEL:     rdata_d = {5'h00, codegen_clock_select_q};
      `MCGCLK_ADDR_MAIN_CTL:    rdata_d = {codegen_power_enable_q, 6'h00, tx_busy};
      `MCGCLK_ADDR_TX_DATA:     rdata_d = shift_q;
      `MCGCLK_ADDR_PORT3_LATCH: rdata_d = port3_pin_in;
      default:                  rdata_d = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// >>> hw/mcgclk_defs.vh
// Contract
// - Codes 0-5 divide clock by 1..32; 6,7 prohibited.
// - Clock select resets to zero, upper bits zero.
// - Port direction register resets to all ones.
// - Direction bit 0 drives pin, 1 releases.
`ifndef MCGCLK_DEFS_VH
`define MCGCLK_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MCGCLK_ADDR_PORT3_DIR   16'hff23
`define MCGCLK_ADDR_CLK_SEL     16'hff4d
`define MCGCLK_ADDR_MAIN_CTL    16'hff4c
`define MCGCLK_ADDR_TX_DATA     16'hff4e
`define MCGCLK_ADDR_PORT3_LATCH 16'hff03
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MCGCLK_POWER_BIT        7
`define MCGCLK_BUSY_BIT         0
`define MCGCLK_CODED_PIN        2
`define MCGCLK_SEL_MAX          3'h5
`define MCGCLK_LAST_BIT         3'h7
`define MCGCLK_RST_BIT_CNT      3'h0
`define MCGCLK_RST_PORT3_DIR    8'hff
`define MCGCLK_RST_CLK_SEL      3'h0
`define MCGCLK_RST_ZERO         8'h00
`endif

// >>> hw/mcgclk_div.v
`include "mcgclk_defs.vh"
`default_nettype none
module mcgclk_div #(
  parameter CW = 5
) (
  input  wire         ref_clk_in,
  input  wire         resetn_in,
  input  wire         run_in,
  input  wire [2:0]   sel_in,
  output reg          tick_out
);
  reg  [CW-1:0] cnt_q;
  wire [CW-1:0] mask;
  wire          legal;

  assign legal = (sel_in <= `MCGCLK_SEL_MAX);
  assign mask  = ~({CW{1'b1}} << sel_in);

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q    <= {CW{1'b0}};
      tick_out <= 1'b0;
    end else if (!run_in || !legal) begin
      // Prohibited codes stall the base clock rather than guess a ratio.
      cnt_q    <= {CW{1'b0}};
      tick_out <= 1'b0;
    end else begin
      cnt_q    <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      tick_out <= ((cnt_q & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// >>> verification/mcgclk_asserts.sv
`default_nettype none
module mcgclk_asserts (
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic [15:0] sfr_addr_in,
  input wire logic [7:0]  sfr_wdata_in,
  input wire logic        sfr_wr_in,
  input wire logic        sfr_rd_in,
  input wire logic [7:0]  sfr_rdata_out,
  input wire logic [7:0]  port3_oe_out,
  input wire logic [7:0]  port3_out,
  input wire logic        coded_serial_out
);
  timeunit 1ns / 1ns;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_oe_reset: assert property ($rose(resetn_in) |-> port3_oe_out == 8'h00)
    else $error("oe driven after reset");
  a_oe_follow: assert property (sfr_wr_in && sfr_addr_in == 16'hff23 |-> ##2
    port3_oe_out == ~$past(sfr_wdata_in, 2)) else $error("oe not inverse of direction");
  a_sel_upper: assert property (sfr_rd_in && sfr_addr_in == 16'hff4d |=>
    sfr_rdata_out[7:3] == 5'h00) else $error("select upper bits set");
  a_oe_hold: assert property (!$past(sfr_wr_in && sfr_addr_in == 16'hff23) |=>
    $stable(port3_oe_out)) else $error("oe moved without direction write");
  a_off_quiet: assert property (sfr_wr_in && sfr_addr_in == 16'hff4c && !sfr_wdata_in[7]
    |-> ##2 !coded_serial_out) else $error("line not low after power off");
  a_pin_mirror: assert property (coded_serial_out |=> port3_out[2])
    else $error("coded stream missing from pin");
endmodule
bind mcgclk_top mcgclk_asserts chk_u (.ref_clk_in, .resetn_in, .sfr_addr_in, .sfr_wdata_in,
  .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .port3_oe_out, .port3_out, .coded_serial_out);
`default_nettype wire

// >>> verification/mcgclk_rx_model.sv
`default_nettype none
module mcgclk_rx_model (
  input  wire logic       clk_in,
  input  wire logic       line_in,
  input  wire logic [2:0] sel_in,
  output var logic  [7:0] data_out,
  output var logic        got_out
);
  timeunit 1ns / 1ns;
  int h;
  initial got_out = 1'b0;
  // Only a leading zero rises out of idle at the start of its bit period, so every frame must start with a zero.
  always begin
    @(negedge clk_in iff line_in);
    h = 1 << sel_in;
    repeat (h / 2) @(negedge clk_in);
    repeat (8) begin
      data_out = {data_out[6:0], ~line_in};
      repeat (2 * h) @(negedge clk_in);
    end
    got_out = 1'b1;
    @(negedge clk_in);
    got_out = 1'b0;
  end
endmodule
`default_nettype wire

// >>> verification/manchester_code_generator_clocking_tb.sv
`default_nettype none
module manchester_code_generator_clocking_tb;
  timeunit 1ns / 1ns;
  logic        ref_clk_in = 1'b0, resetn_in = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic        ser, got;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata, p3_out, p3_oe, rx_data, rq[$], tq[$];
  logic [2:0]  sel = 3'h0;
  logic [31:0] lf = 32'h0000_bba9;
  int          fails = 0, checks_done = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  mcgclk_top dut_u (.ref_clk_in, .resetn_in, .sfr_addr_in(addr), .sfr_wdata_in(wdata),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .port3_pin_in(p3_out), .sfr_rdata_out(rdata),
    .port3_out(p3_out), .port3_oe_out(p3_oe), .coded_serial_out(ser));
  mcgclk_rx_model rx_u (.clk_in(ref_clk_in), .line_in(ser), .sel_in(sel),
    .data_out(rx_data), .got_out(got));
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(logic w, logic [15:0] a, logic [7:0] d);
    @(negedge ref_clk_in);
    {addr, wdata, wr, rd} = {a, d, w, !w};
    if (!w) rq.push_back(d);
    @(negedge ref_clk_in);
    {wr, rd} = 2'b00;
  endtask
  always @(posedge ref_clk_in) begin
    rd_d <= rd;
    if (rd_d) chk(rdata, rq.pop_front());
    if (got) chk(rx_data, tq.pop_front());
  end
  initial begin
    repeat (3) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    acc(0, 16'hff23, 8'hff);
    acc(0, 16'hff4d, 8'h00);
    acc(1, 16'hff23, 8'hfb);
    acc(1, 16'hff03, 8'h00);
    chk(p3_oe, 8'h04);
    acc(0, 16'hff03, 8'h00);
    acc(0, 16'hff23, 8'hfb);
    for (int s = 0; s < 6; s++) begin
      lf = nx(lf);
      acc(1, 16'hff4c, 8'h00);
      acc(1, 16'hff4d, {lf[7:3], s[2:0]});
      acc(0, 16'hff4d, {5'h00, s[2:0]});
      sel = s[2:0];
      acc(1, 16'hff4c, 8'h80);
      tq.push_back({1'b0, lf[14:8]});
      acc(1, 16'hff4e, {1'b0, lf[14:8]});
      repeat (3000) if (!got) @(posedge ref_clk_in);
      if (!got) begin
        fails++;
        give_verdict();
      end
      @(negedge ref_clk_in);
    end
    // A prohibited code must stall the frame: busy stays set, data stays put.
    acc(1, 16'hff4c, 8'h00);
    acc(1, 16'hff4d, {lf[23:19], 3'h6});
    acc(1, 16'hff4c, 8'h80);
    acc(1, 16'hff4e, lf[31:24]);
    repeat (200) @(negedge ref_clk_in);
    acc(0, 16'hff4c, 8'h81);
    acc(0, 16'hff4e, lf[31:24]);
    acc(1, 16'hff4c, 8'h00);
    acc(0, 16'hff4c, 8'h00);
    repeat (2) @(negedge ref_clk_in);
    give_verdict();
  end
endmodule
`default_nettype wire
